// file: hw/rcf_regs.svh
`ifndef RCF_REGS_SVH
`define RCF_REGS_SVH

// widths
`define RCF_NFLAG 11
`define RCF_NEVT 12
`define RCF_AW 8
`define RCF_DW 32
`define RCF_A_W 3
`define RCF_B_W 8

// detect flag positions inside the internal flag vector
`define RCF_F_IWDT 0
`define RCF_F_WDT 1
`define RCF_F_VMON1 2
`define RCF_F_VMON2 3
`define RCF_F_SW 4
`define RCF_F_PAR 5
`define RCF_F_ECC 6
`define RCF_F_BUSM 7
`define RCF_F_SEC 8
`define RCF_F_CACHE 9
`define RCF_F_DEEP 10
// event vector adds the voltage monitor 0 source on top
`define RCF_E_VMON0 11

// clear masks per reset source, laid out as the flag vector
`define RCF_VM0_CLR 11'h7FF
`define RCF_DS0_CLR 11'h3F3
`define RCF_DS1_CLR 11'h003
`define RCF_NO_CLR 11'h000
`define RCF_FLAG_RST 11'h000
`define RCF_EVT_RST 12'h000
`define RCF_DATA_RST 32'h0000_0000

// register offsets
`define RCF_OFF_STAT_A 8'h00
`define RCF_OFF_STAT_B 8'h04
`define RCF_OFF_IRQ_ST 8'h08
`define RCF_OFF_IRQ_EN 8'h0C
`define RCF_OFF_IRQ_CLR 8'h10

// field positions in reset_status_reg_a
`define RCF_A_VMON1 0
`define RCF_A_VMON2 1
`define RCF_A_DEEP 2
// field positions in reset_status_reg_b
`define RCF_B_IWDT 0
`define RCF_B_WDT 1
`define RCF_B_SW 2
`define RCF_B_PAR 3
`define RCF_B_ECC 4
`define RCF_B_BUSM 5
`define RCF_B_SEC 6
`define RCF_B_CACHE 7

`endif

// file: hw/rcf_pkg.sv
`include "rcf_regs.svh"
package rcf_pkg;
  typedef logic [`RCF_NFLAG-1:0] rcf_flags_t;
  typedef logic [`RCF_NEVT-1:0] rcf_events_t;
  typedef logic [`RCF_AW-1:0] rcf_addr_t;
  typedef logic [`RCF_DW-1:0] rcf_data_t;
endpackage : rcf_pkg

// file: hw/rcf_sticky.sv
`include "rcf_regs.svh"
module rcf_sticky #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] q
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      wire next_q = set[i] | (q[i] & ~clr[i]);
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          q[i] <= 1'b0;
        end else if (clk_en) begin
          // set wins over a clear in the same cycle
          q[i] <= next_q;
        end
      end
    end
  endgenerate
endmodule : rcf_sticky

// file: hw/rcf_clear_map.sv
`include "rcf_regs.svh"
module rcf_clear_map (
  input wire logic ev_vmon0,
  input wire logic ev_deep_standby,
  input wire logic deep_standby_cut_select,
  output rcf_pkg::rcf_flags_t clr
);
  wire rcf_pkg::rcf_flags_t vm0_clr;
  wire rcf_pkg::rcf_flags_t ds_clr;
  // every other source contributes nothing here
  assign vm0_clr = ev_vmon0 ? `RCF_VM0_CLR : `RCF_NO_CLR;
  assign ds_clr = !ev_deep_standby ? `RCF_NO_CLR :
                  deep_standby_cut_select ? `RCF_DS1_CLR :
                  `RCF_DS0_CLR;
  assign clr = vm0_clr | ds_clr;
endmodule : rcf_clear_map

// file: hw/rcf_flags.sv
// Summary of operation
// - voltage monitor 0 reset clears all listed flags
// - voltage monitor 1 reset clears no flags
// - voltage monitor 2 reset clears no flags
// - SRAM parity reset clears no flags
// - SRAM ECC reset clears no flags
// - bus master protection reset clears no flags
// - cache parity, security attribute resets clear none
// - deep standby, cut low, clears eight flags
// - deep standby, cut high, clears both watchdog flags
`include "rcf_regs.svh"
module rcf_flags (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic ev_vmon0,
  input wire logic ev_indep_wdt,
  input wire logic ev_wdt,
  input wire logic ev_vmon1,
  input wire logic ev_vmon2,
  input wire logic ev_sw,
  input wire logic ev_sram_parity,
  input wire logic ev_sram_ecc,
  input wire logic ev_bus_master_prot,
  input wire logic ev_security_attr,
  input wire logic ev_cache_parity,
  input wire logic ev_deep_standby,
  input wire logic deep_standby_cut_select,
  input wire rcf_pkg::rcf_addr_t addr,
  input wire rcf_pkg::rcf_data_t wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output rcf_pkg::rcf_data_t rd_data,
  output logic irq
);
  wire rcf_pkg::rcf_flags_t set_vec;
  wire rcf_pkg::rcf_flags_t src_clr;
  wire rcf_pkg::rcf_flags_t sw_clr;
  wire rcf_pkg::rcf_flags_t flag_clr;
  wire rcf_pkg::rcf_flags_t flags;
  wire rcf_pkg::rcf_events_t evt_vec;
  wire rcf_pkg::rcf_events_t irq_clr;
  wire rcf_pkg::rcf_events_t irq_st;
  rcf_pkg::rcf_events_t irq_en;

  // each source except voltage monitor 0 sets its own detect flag
  assign set_vec[`RCF_F_IWDT] = ev_indep_wdt;
  assign set_vec[`RCF_F_WDT] = ev_wdt;
  assign set_vec[`RCF_F_VMON1] = ev_vmon1;
  assign set_vec[`RCF_F_VMON2] = ev_vmon2;
  assign set_vec[`RCF_F_SW] = ev_sw;
  assign set_vec[`RCF_F_PAR] = ev_sram_parity;
  assign set_vec[`RCF_F_ECC] = ev_sram_ecc;
  assign set_vec[`RCF_F_BUSM] = ev_bus_master_prot;
  assign set_vec[`RCF_F_SEC] = ev_security_attr;
  assign set_vec[`RCF_F_CACHE] = ev_cache_parity;
  assign set_vec[`RCF_F_DEEP] = ev_deep_standby;
  assign evt_vec = {ev_vmon0, set_vec};

  // bus decode
  wire sel_a = (addr == `RCF_OFF_STAT_A);
  wire sel_b = (addr == `RCF_OFF_STAT_B);
  wire sel_ist = (addr == `RCF_OFF_IRQ_ST);
  wire sel_ien = (addr == `RCF_OFF_IRQ_EN);
  wire sel_icl = (addr == `RCF_OFF_IRQ_CLR);
  wire wr_a = wr_en & sel_a;
  wire wr_b = wr_en & sel_b;
  wire wr_ien = wr_en & sel_ien;
  wire wr_icl = wr_en & sel_icl;

  // software clears a detect flag by writing one to its bit
  assign sw_clr[`RCF_F_VMON1] = wr_a & wr_data[`RCF_A_VMON1];
  assign sw_clr[`RCF_F_VMON2] = wr_a & wr_data[`RCF_A_VMON2];
  assign sw_clr[`RCF_F_DEEP] = wr_a & wr_data[`RCF_A_DEEP];
  assign sw_clr[`RCF_F_IWDT] = wr_b & wr_data[`RCF_B_IWDT];
  assign sw_clr[`RCF_F_WDT] = wr_b & wr_data[`RCF_B_WDT];
  assign sw_clr[`RCF_F_SW] = wr_b & wr_data[`RCF_B_SW];
  assign sw_clr[`RCF_F_PAR] = wr_b & wr_data[`RCF_B_PAR];
  assign sw_clr[`RCF_F_ECC] = wr_b & wr_data[`RCF_B_ECC];
  assign sw_clr[`RCF_F_BUSM] = wr_b & wr_data[`RCF_B_BUSM];
  assign sw_clr[`RCF_F_SEC] = wr_b & wr_data[`RCF_B_SEC];
  assign sw_clr[`RCF_F_CACHE] = wr_b & wr_data[`RCF_B_CACHE];

  // only voltage monitor 0 and deep standby produce a source clear
  rcf_clear_map u_map (
    .ev_vmon0(ev_vmon0),
    .ev_deep_standby(ev_deep_standby),
    .deep_standby_cut_select(deep_standby_cut_select),
    .clr(src_clr)
  );

  assign flag_clr = src_clr | sw_clr;

  rcf_sticky #(.W(`RCF_NFLAG)) u_flags (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .set(set_vec),
    .clr(flag_clr),
    .q(flags)
  );

  // interrupt status: one sticky bit per reset source event
  assign irq_clr = wr_icl ? wr_data[`RCF_NEVT-1:0] : `RCF_EVT_RST;

  rcf_sticky #(.W(`RCF_NEVT)) u_irq_st (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .set(evt_vec),
    .clr(irq_clr),
    .q(irq_st)
  );

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_en <= `RCF_EVT_RST;
    end else if (clk_en && wr_ien) begin
      irq_en <= wr_data[`RCF_NEVT-1:0];
    end
  end

  wire next_irq = |(irq_st & irq_en);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= next_irq;
    end
  end

  // read mux, zero for unmapped offsets and the write-only clear word
  wire [`RCF_A_W-1:0] stat_a = {flags[`RCF_F_DEEP], flags[`RCF_F_VMON2],
                                flags[`RCF_F_VMON1]};
  wire [`RCF_B_W-1:0] stat_b = {flags[`RCF_F_CACHE], flags[`RCF_F_SEC],
                                flags[`RCF_F_BUSM], flags[`RCF_F_ECC],
                                flags[`RCF_F_PAR], flags[`RCF_F_SW],
                                flags[`RCF_F_WDT], flags[`RCF_F_IWDT]};
  wire rcf_pkg::rcf_data_t rd_a = {{(`RCF_DW-`RCF_A_W){1'b0}}, stat_a};
  wire rcf_pkg::rcf_data_t rd_b = {{(`RCF_DW-`RCF_B_W){1'b0}}, stat_b};
  wire rcf_pkg::rcf_data_t rd_ist = {{(`RCF_DW-`RCF_NEVT){1'b0}}, irq_st};
  wire rcf_pkg::rcf_data_t rd_ien = {{(`RCF_DW-`RCF_NEVT){1'b0}}, irq_en};
  wire rcf_pkg::rcf_data_t rd_mux = sel_a ? rd_a :
                                    sel_b ? rd_b :
                                    sel_ist ? rd_ist :
                                    sel_ien ? rd_ien : `RCF_DATA_RST;
  wire rcf_pkg::rcf_data_t next_rd_data = rd_en ? rd_mux : `RCF_DATA_RST;

  // data stand for one cycle only, then return to zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_data <= `RCF_DATA_RST;
    end else if (clk_en) begin
      rd_data <= next_rd_data;
    end
  end

  // helper terms: a cycle in which no source clear and no software clear
  wire quiet = clk_en & ~ev_vmon0 & ~ev_deep_standby & ~wr_a & ~wr_b;
  wire no_set = ~(|set_vec);

  AST_VM0_CLEARS: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_en && ev_vmon0 && no_set) |=> (flags == `RCF_NO_CLR))
    else $error("voltage monitor 0 reset left a flag set");

  AST_VM1_KEEPS: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (quiet && ev_vmon1) |=> ((flags & $past(flags)) == $past(flags)))
    else $error("voltage monitor 1 reset cleared a flag");

  AST_VM2_KEEPS: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (quiet && ev_vmon2) |=> ((flags & $past(flags)) == $past(flags)))
    else $error("voltage monitor 2 reset cleared a flag");

  AST_PAR_KEEPS: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (quiet && ev_sram_parity) |=>
      ((flags & $past(flags)) == $past(flags)))
    else $error("SRAM parity reset cleared a flag");

  AST_ECC_KEEPS: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (quiet && ev_sram_ecc) |=> ((flags & $past(flags)) == $past(flags)))
    else $error("SRAM ECC reset cleared a flag");

  AST_BUSM_KEEPS: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (quiet && ev_bus_master_prot) |=>
      ((flags & $past(flags)) == $past(flags)))
    else $error("bus master protection reset cleared a flag");

  AST_CACHE_SEC_KEEPS: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (quiet && (ev_cache_parity || ev_security_attr)) |=>
      ((flags & $past(flags)) == $past(flags)))
    else $error("cache or security reset cleared a flag");

  AST_DS_CUT0: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_en && ev_deep_standby && !deep_standby_cut_select && !ev_vmon0
     && !wr_a && !wr_b) |=>
      (flags == ($past(set_vec) | ($past(flags) & ~`RCF_DS0_CLR))))
    else $error("deep standby cut low cleared the wrong flags");

  AST_DS_CUT1: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_en && ev_deep_standby && deep_standby_cut_select
     && !ev_indep_wdt && !ev_wdt && !ev_vmon0) |=>
      (!flags[`RCF_F_IWDT] && !flags[`RCF_F_WDT]))
    else $error("deep standby cut high kept a watchdog flag");

  AST_SET_WINS: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_en && ev_wdt) |=> flags[`RCF_F_WDT] [*1] ##0
      (!clk_en || quiet || flags[`RCF_F_WDT]))
    else $error("watchdog event did not set its flag");

  AST_HOLD: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (quiet && no_set) |=> (flags == $past(flags)))
    else $error("detect flags changed with no cause");

  AST_IRQ_LEVEL: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en |=> (irq == $past(|(irq_st & irq_en))))
    else $error("interrupt output disagrees with enabled status");

  AST_READ_A: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_en && rd_en && sel_a) |=>
      (rd_data[`RCF_A_VMON1] == $past(flags[`RCF_F_VMON1]) &&
       rd_data[`RCF_DW-1:`RCF_A_W] == '0))
    else $error("status register a read returned wrong data");

  AST_DS_CUT1_KEEPS: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_en && ev_deep_standby && deep_standby_cut_select && !ev_vmon0
     && !wr_a && !wr_b) |=>
      (flags == ($past(set_vec) | ($past(flags) & ~`RCF_DS1_CLR))))
    else $error("deep standby cut high cleared an unlisted flag");

  AST_SET_EACH: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_en && !no_set) |=> ((flags & $past(set_vec)) == $past(set_vec)))
    else $error("a reset event did not set its own flag");

  AST_DS_SETS_DEEP: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_en && ev_deep_standby) |=> flags[`RCF_F_DEEP])
    else $error("deep standby reset did not set its flag");

  AST_VM0_IRQ_ST: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_en && ev_vmon0) |=> irq_st[`RCF_E_VMON0])
    else $error("voltage monitor 0 event missing from irq status");

  AST_IRQ_ST_SET: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_en && |evt_vec) |=> ((irq_st & $past(evt_vec)) == $past(evt_vec)))
    else $error("an event did not set its irq status bit");

  AST_SW_CLR: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_en && no_set && (wr_a || wr_b)) |=>
      ((flags & $past(sw_clr)) == `RCF_NO_CLR))
    else $error("write one to a status bit left the flag set");

  AST_FREEZE: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !clk_en |=> (flags == $past(flags) && irq_st == $past(irq_st) &&
                 irq_en == $past(irq_en) && irq == $past(irq) &&
                 rd_data == $past(rd_data)))
    else $error("state moved while the clock enable was low");

  AST_IRQ_EN_WR: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_en && wr_ien) |=> (irq_en == $past(wr_data[`RCF_NEVT-1:0])))
    else $error("irq enable write did not land");

  AST_IRQ_CLR: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_en && wr_icl && !(|evt_vec)) |=>
      ((irq_st & $past(wr_data[`RCF_NEVT-1:0])) == `RCF_EVT_RST))
    else $error("irq clear write left a status bit set");

  AST_RD_IDLE: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_en && !rd_en) |=> (rd_data == `RCF_DATA_RST))
    else $error("read data stood beyond its one cycle");

  AST_READ_B: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_en && rd_en && sel_b) |=>
      (rd_data[`RCF_B_WDT] == $past(flags[`RCF_F_WDT]) &&
       rd_data[`RCF_B_CACHE] == $past(flags[`RCF_F_CACHE]) &&
       rd_data[`RCF_DW-1:`RCF_B_W] == '0))
    else $error("status register b read returned wrong data");

  AST_RD_UNMAP: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_en && rd_en && !sel_a && !sel_b && !sel_ist && !sel_ien) |=>
      (rd_data == `RCF_DATA_RST))
    else $error("unmapped or write-only read returned data");

endmodule : rcf_flags

// file: tb/tb.sv
`include "rcf_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk;
  logic rst_n;
  logic clk_en;
  logic cut;
  logic wr_en;
  logic rd_en;
  logic irq;
  logic [11:0] ev_v;
  logic [11:0] exp_s;
  rcf_pkg::rcf_addr_t addr;
  rcf_pkg::rcf_data_t wr_data;
  rcf_pkg::rcf_data_t rd_data;
  rcf_pkg::rcf_data_t got;
  rcf_pkg::rcf_flags_t exp_f;
  int error_cnt;
  int checked;

  rcf_flags dut_u (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .ev_vmon0(ev_v[11]),
    .ev_indep_wdt(ev_v[0]),
    .ev_wdt(ev_v[1]),
    .ev_vmon1(ev_v[2]),
    .ev_vmon2(ev_v[3]),
    .ev_sw(ev_v[4]),
    .ev_sram_parity(ev_v[5]),
    .ev_sram_ecc(ev_v[6]),
    .ev_bus_master_prot(ev_v[7]),
    .ev_security_attr(ev_v[8]),
    .ev_cache_parity(ev_v[9]),
    .ev_deep_standby(ev_v[10]),
    .deep_standby_cut_select(cut),
    .addr(addr),
    .wr_data(wr_data),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rd_data(rd_data),
    .irq(irq)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task final_report;
    $display("mismatches %0d comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  task chk(input rcf_pkg::rcf_data_t g, input rcf_pkg::rcf_data_t e,
           input string m);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  task wr(input rcf_pkg::rcf_addr_t a, input rcf_pkg::rcf_data_t d);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask : wr

  task rd_chk(input rcf_pkg::rcf_addr_t a, input rcf_pkg::rcf_data_t e,
              input string m);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 got = rd_data;
    chk(got, e, m);
  endtask : rd_chk

  // both status registers against the flag model
  task chk_flags;
    rd_chk(`RCF_OFF_STAT_A, {29'h0, exp_f[10], exp_f[3:2]}, "stat_a");
    rd_chk(`RCF_OFF_STAT_B, {24'h0, exp_f[9:4], exp_f[1:0]}, "stat_b");
  endtask : chk_flags

  // one-cycle event pulse; the model lets a set win over any clear
  task pulse(input logic [11:0] e, input logic c, input logic en);
    logic [10:0] clr;
    clr = e[11] ? 11'h7FF : (e[10] ? (c ? 11'h003 : 11'h3F3) : 11'h000);
    @(posedge sys_clk);
    ev_v <= e;
    cut <= c;
    clk_en <= en;
    @(posedge sys_clk);
    ev_v <= 12'h000;
    clk_en <= 1'b1;
    if (en) begin
      exp_f = (exp_f & ~clr) | e[10:0];
      exp_s = exp_s | e;
    end
  endtask : pulse

  task irq_chk(input logic e, input string m);
    repeat (2) @(posedge sys_clk);
    #1 chk({31'h0, irq}, {31'h0, e}, m);
  endtask : irq_chk

  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    cut = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    ev_v = 12'h000;
    addr = 8'h00;
    wr_data = 32'h0000_0000;
    exp_f = 11'h000;
    exp_s = 12'h000;
    error_cnt = 0;
    checked = 0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    chk_flags;
    for (int i = 0; i < 10; i++) begin
      pulse(12'h001 << i, 1'b0, 1'b1);
      chk_flags;
    end
    // every non-clearing source, with the other nine non-clearing flags standing and the deep standby flag clear
    for (int i = 0; i < 10; i++) begin
      pulse(12'h001 << i, 1'b0, 1'b1);
      chk_flags;
    end
    pulse(12'h400, 1'b0, 1'b1);
    chk_flags;
    pulse(12'h3FF, 1'b0, 1'b1);
    pulse(12'h400, 1'b1, 1'b1);
    chk_flags;
    pulse(12'h800, 1'b0, 1'b1);
    chk_flags;
    pulse(12'h802, 1'b0, 1'b1);
    chk_flags;
    rd_chk(`RCF_OFF_IRQ_ST, {20'h0, exp_s}, "irq_st all");
    // a pulse while the clock enable is low must be lost
    pulse(12'h001, 1'b0, 1'b0);
    chk_flags;
    wr(`RCF_OFF_STAT_B, 32'h0000_0002);
    exp_f[1] = 1'b0;
    chk_flags;
    wr(`RCF_OFF_IRQ_CLR, 32'h0000_0FFF);
    exp_s = 12'h000;
    rd_chk(`RCF_OFF_IRQ_ST, 32'h0, "irq_st");
    wr(`RCF_OFF_IRQ_EN, 32'h0000_0002);
    rd_chk(`RCF_OFF_IRQ_EN, 32'h0000_0002, "irq_en");
    pulse(12'h004, 1'b0, 1'b1);
    irq_chk(1'b0, "irq masked");
    pulse(12'h002, 1'b0, 1'b1);
    irq_chk(1'b1, "irq raised");
    rd_chk(`RCF_OFF_IRQ_ST, {20'h0, exp_s}, "irq_st");
    @(posedge sys_clk);
    #1 chk(rd_data, 32'h0, "rd_data idle");
    wr(`RCF_OFF_IRQ_CLR, 32'h0000_0002);
    exp_s[1] = 1'b0;
    irq_chk(1'b0, "irq cleared");
    wr(`RCF_OFF_IRQ_ST, 32'h0000_0FFF);
    rd_chk(`RCF_OFF_IRQ_ST, {20'h0, exp_s}, "irq_st ro");
    rd_chk(`RCF_OFF_IRQ_CLR, 32'h0, "irq_clr wo");
    rd_chk(8'h14, 32'h0, "unmapped");
    // set every flag, then clear register a by writing ones
    pulse(12'h7FF, 1'b0, 1'b1);
    wr(`RCF_OFF_STAT_A, 32'h0000_0007);
    exp_f = exp_f & 11'h3F3;
    chk_flags;
    // second reset in mid-run must wipe a standing state
    wr(`RCF_OFF_IRQ_EN, 32'h0000_0FFF);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    @(posedge sys_clk);
    rst_n <= 1'b1;
    exp_f = 11'h000;
    chk_flags;
    rd_chk(`RCF_OFF_IRQ_ST, 32'h0, "irq_st reset");
    rd_chk(`RCF_OFF_IRQ_EN, 32'h0, "irq_en reset");
    irq_chk(1'b0, "irq reset");
    final_report;
  end

  // whole sequence needs a few hundred cycles
  initial begin
    #20000;
    error_cnt++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    final_report;
  end
endmodule : tb
